/* logic/uepc_params.svh */
// Purpose: Constants for the one-time-writable memory programmer controller.
// Assumes: 25 MHz core clock; supply switches driven as logic levels.
// Notes:   Timing counts are times over the clock period; setup and gate counts rounded up.
// How it works
// R01: Supplies at program levels only in program, verify and inhibit modes.
// R02: Memory drives data only with select and output gate both low.
// R03: Data valid one output-gate delay after gate falls, select already low.
// R04: Select high gives standby; outputs float regardless of output gate.
// R05: Gate high with select low floats outputs; circuitry stays active.
// R06: Select decoded per device; output gate shared with system read strobe.
// R07: Erased bits read one; programming only clears bits to zero.
// R08: Program mode needs elevated programming supply and output gate high.
// R09: Programmer drives the full 16-bit word and address during programming.
// R10: Each active-low program pulse applied only once address and data stable.
// R11: Repeat 100 us pulses with verify after each, at most 25 per address.
// R12: Program strobe never held low statically; pulses always bounded.
// R13: Like inputs may be shared so one pulse programs several devices.
// R14: Select high inhibits programming so parallel devices differ in data.
// R15: Verify may run with elevated supply; otherwise supplies equal.
// R16: Id read: id line at 12V, others low, byte select picks byte.
// R17: Main supply on first, off last relative to programming supply.
// R18: Program strobe high before or with programming supply at power-up.
// R19: Read mode ignores program strobe and programming supply level.
// R20: Verify mode with select, gate low and strobe high drives stored word.
// R21: Memory model shows stored word under read or verify, else floats.
`ifndef UEPC_PARAMS_SVH
`define UEPC_PARAMS_SVH
`define UEPC_CLK_NS        40
`define UEPC_PULSE_NS      100000
`define UEPC_PULSE_CYC     (`UEPC_PULSE_NS / `UEPC_CLK_NS)
`define UEPC_SETUP_NS      1000
`define UEPC_SETUP_CYC     ((`UEPC_SETUP_NS + `UEPC_CLK_NS - 1) / `UEPC_CLK_NS)
`define UEPC_OE_NS         150
`define UEPC_OE_CYC        ((`UEPC_OE_NS + `UEPC_CLK_NS - 1) / `UEPC_CLK_NS)
`define UEPC_MAX_PULSES    25
`define UEPC_ALL_ONES      16'hffff
`endif

/* logic/uepc_pkg.sv */
// Purpose: Types for the programmer controller.
// Assumes: One clock domain.
// Notes:   State is a single packed struct.
`default_nettype none
package uepc_pkg;
   typedef enum logic [1:0] {
      UEPC_OP_READ = 2'h0,
      UEPC_OP_PROG = 2'h1,
      UEPC_OP_ID   = 2'h2
   } uepc_op_t;

   typedef enum logic [7:0] {
      UEPC_IDLE   = 8'h01,
      UEPC_PWRUP  = 8'h02,
      UEPC_SETUP  = 8'h04,
      UEPC_PULSE  = 8'h08,
      UEPC_HOLD   = 8'h10,
      UEPC_VERIFY = 8'h20,
      UEPC_PWRDN  = 8'h40,
      UEPC_RDONE  = 8'h80
   } uepc_state_t;

   typedef struct packed {
      logic        sel_n;
      logic        gate_n;
      logic        program_strobe_n;
      logic        vpp_high;
      logic        vcc_high;
      logic        id_high_voltage;
      logic [15:0] addr;
      logic [15:0] dout;
      logic        dout_oe_n;
   } uepc_pins_t;

   typedef struct packed {
      uepc_state_t state;
      uepc_op_t    op;
      uepc_pins_t  pins;
      logic [15:0] cnt;
      logic [4:0]  pulses;
      logic [15:0] rdata;
      logic [15:0] data;
      logic        done;
      logic        fail;
      logic        busy;
   } uepc_regs_t;
endpackage
`default_nettype wire

/* logic/uepc_ctrl.sv */
// Purpose: Drives the memory pins to read, program with verify, and read id.
// Assumes: Memory data pins sampled synchronously; supply switches external.
// Notes:   One command at a time; busy blocks new commands.
`timescale 1ns/1ps
`default_nettype none
`include "uepc_params.svh"
module uepc_ctrl
   import uepc_pkg::*;
#(
   parameter int PULSE_CYC = `UEPC_PULSE_CYC,
   parameter int MAX_PULSES = `UEPC_MAX_PULSES
) (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_I,
   input  wire logic        CMD_VALID_I,
   input  wire logic [1:0]  CMD_OP_I,
   input  wire logic [15:0] CMD_ADDR_I,
   input  wire logic [15:0] CMD_DATA_I,
   output logic             BUSY_O,
   output logic             DONE_O,
   output logic             FAIL_O,
   output logic [15:0]      RDATA_O,
   output logic             SEL_N_O,
   output logic             GATE_N_O,
   output logic             PROGRAM_STROBE_N_O,
   output logic             VPP_HIGH_O,
   output logic             VCC_HIGH_O,
   output logic             ID_HIGH_VOLTAGE_O,
   output logic [15:0]      ADDR_O,
   output logic [15:0]      DQ_O,
   output logic             DQ_OE_N_O,
   input  wire logic [15:0] DQ_I
);
   localparam logic [15:0] SETUP_C = 16'(`UEPC_SETUP_CYC);
   localparam logic [15:0] OE_C    = 16'(`UEPC_OE_CYC);
   localparam logic [15:0] PULSE_C = 16'(PULSE_CYC);
   localparam logic [4:0]  MAXP_C  = 5'(MAX_PULSES);

   uepc_regs_t  r_ff;
   uepc_regs_t  nxt_r;
   logic        cnt_zero;
   logic [16:0] low_cnt_ff;

   default clocking @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);

   assign cnt_zero = (r_ff.cnt == 16'h0000);

   always_comb begin
      nxt_r = r_ff;
      nxt_r.done = 1'b0;
      if (!cnt_zero) begin
         nxt_r.cnt = r_ff.cnt - 16'h0001;
      end
      unique case (r_ff.state)
         UEPC_IDLE: begin
            if (CMD_VALID_I) begin
               nxt_r.op = uepc_op_t'(CMD_OP_I);
               nxt_r.busy = 1'b1;
               nxt_r.fail = 1'b0;
               nxt_r.pulses = 5'h00;
               nxt_r.data = CMD_DATA_I;
               nxt_r.pins.addr = CMD_ADDR_I;
               nxt_r.cnt = SETUP_C;
               if (uepc_op_t'(CMD_OP_I) == UEPC_OP_PROG) begin
                  // Strobe high and gate high as main supply rises, before programming supply
                  nxt_r.pins.gate_n = 1'b1;        // see R08
                  nxt_r.pins.program_strobe_n = 1'b1; // see R18
                  nxt_r.pins.vcc_high = 1'b1;      // see R17
                  nxt_r.state = UEPC_PWRUP;
               end else begin
                  if (uepc_op_t'(CMD_OP_I) == UEPC_OP_ID) begin
                     // Id read wants all controls low
                     nxt_r.pins.addr = {15'h0000, CMD_ADDR_I[0]};
                     nxt_r.pins.id_high_voltage = 1'b1; // see R16
                     nxt_r.pins.program_strobe_n = 1'b0;
                  end
                  nxt_r.pins.sel_n = 1'b0;   // see R06
                  nxt_r.pins.gate_n = 1'b0;  // see R02
                  nxt_r.cnt = SETUP_C + OE_C; // see R03
                  nxt_r.state = UEPC_RDONE;
               end
            end
         end
         UEPC_PWRUP: begin
            if (cnt_zero) begin
               nxt_r.pins.vpp_high = 1'b1; // see R01
               nxt_r.pins.dout = r_ff.data; // see R09
               nxt_r.pins.dout_oe_n = 1'b0;
               nxt_r.pins.sel_n = 1'b0;    // see R14
               nxt_r.cnt = SETUP_C;
               nxt_r.state = UEPC_SETUP;
            end
         end
         UEPC_SETUP: begin
            if (cnt_zero) begin
               nxt_r.pins.program_strobe_n = 1'b0; // see R10
               nxt_r.pulses = r_ff.pulses + 5'h01;
               nxt_r.cnt = PULSE_C;
               nxt_r.state = UEPC_PULSE;
            end
         end
         UEPC_PULSE: begin
            // Bounded pulse, never a static low
            if (cnt_zero) begin
               nxt_r.pins.program_strobe_n = 1'b1; // see R12
               nxt_r.cnt = SETUP_C;
               nxt_r.state = UEPC_HOLD;
            end
         end
         UEPC_HOLD: begin
            if (cnt_zero) begin
               nxt_r.pins.dout_oe_n = 1'b1;
               nxt_r.pins.gate_n = 1'b0;   // see R15
               nxt_r.cnt = OE_C;
               nxt_r.state = UEPC_VERIFY;
            end
         end
         UEPC_VERIFY: begin
            if (cnt_zero) begin
               nxt_r.rdata = DQ_I;
               nxt_r.pins.gate_n = 1'b1;
               nxt_r.cnt = SETUP_C;
               if (DQ_I == r_ff.data || r_ff.pulses >= MAXP_C) begin
                  nxt_r.fail = (DQ_I != r_ff.data); // see R11
                  nxt_r.pins.sel_n = 1'b1;
                  nxt_r.pins.vpp_high = 1'b0;     // see R17
                  nxt_r.state = UEPC_PWRDN;
               end else begin
                  nxt_r.pins.dout_oe_n = 1'b0;
                  nxt_r.state = UEPC_SETUP;       // see R11
               end
            end
         end
         UEPC_PWRDN: begin
            if (cnt_zero) begin
               nxt_r.pins.vcc_high = 1'b0; // see R01
               nxt_r.pins.gate_n = 1'b1;
               nxt_r.busy = 1'b0;
               nxt_r.done = 1'b1;
               nxt_r.state = UEPC_IDLE;
            end
         end
         UEPC_RDONE: begin
            if (cnt_zero) begin
               if (r_ff.op == UEPC_OP_ID) begin
                  nxt_r.rdata = {8'h00, DQ_I[7:0]}; // see R16
               end else begin
                  nxt_r.rdata = DQ_I;
               end
               nxt_r.pins.sel_n = 1'b1;
               nxt_r.pins.gate_n = 1'b1;
               nxt_r.pins.id_high_voltage = 1'b0;
               nxt_r.pins.program_strobe_n = 1'b1;
               nxt_r.busy = 1'b0;
               nxt_r.done = 1'b1;
               nxt_r.state = UEPC_IDLE;
            end
         end
         default: begin
            nxt_r.state = UEPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         r_ff <= '{state: UEPC_IDLE, op: UEPC_OP_READ,
                   pins: '{sel_n: 1'b1, gate_n: 1'b1, program_strobe_n: 1'b1,
                           vpp_high: 1'b0, vcc_high: 1'b0,
                           id_high_voltage: 1'b0, addr: 16'h0000,
                           dout: `UEPC_ALL_ONES, dout_oe_n: 1'b1},
                   cnt: 16'h0000, pulses: 5'h00, rdata: 16'h0000,
                   data: `UEPC_ALL_ONES, done: 1'b0, fail: 1'b0,
                   busy: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign BUSY_O = r_ff.busy;
   assign DONE_O = r_ff.done;
   assign FAIL_O = r_ff.fail;
   assign RDATA_O = r_ff.rdata;
   assign SEL_N_O = r_ff.pins.sel_n;
   assign GATE_N_O = r_ff.pins.gate_n;
   // One strobe may fan out to devices that take the same word
   assign PROGRAM_STROBE_N_O = r_ff.pins.program_strobe_n; // see R13
   assign VPP_HIGH_O = r_ff.pins.vpp_high;
   assign VCC_HIGH_O = r_ff.pins.vcc_high;
   assign ID_HIGH_VOLTAGE_O = r_ff.pins.id_high_voltage;
   assign ADDR_O = r_ff.pins.addr;
   assign DQ_O = r_ff.pins.dout;
   assign DQ_OE_N_O = r_ff.pins.dout_oe_n;

   // Helper: cycles the strobe has been low, held at zero during id reads
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I || r_ff.pins.program_strobe_n || r_ff.op == UEPC_OP_ID) begin
         low_cnt_ff <= 17'h00000;
      end else begin
         low_cnt_ff <= low_cnt_ff + 17'h00001;
      end
   end

   a_pulse_bounded: assert property ( // see R12
      low_cnt_ff <= 17'(PULSE_CYC + 1))
      else $error("program strobe low too long");
   a_vpp_needs_vcc: assert property ( // see R17
      VPP_HIGH_O |-> VCC_HIGH_O)
      else $error("programming supply high without main supply");
   a_strobe_pwrup: assert property ( // see R18
      $rose(VPP_HIGH_O) |-> PROGRAM_STROBE_N_O)
      else $error("strobe low when programming supply rose");
   a_prog_gate_high: assert property ( // see R08
      !PROGRAM_STROBE_N_O && VPP_HIGH_O |-> GATE_N_O && !SEL_N_O)
      else $error("pulse without gate high and select low");
   a_pulse_count: assert property ( // see R11
      r_ff.pulses <= MAXP_C)
      else $error("too many pulses");
   a_data_driven: assert property ( // see R09
      !PROGRAM_STROBE_N_O && VPP_HIGH_O |-> !DQ_OE_N_O && DQ_O == r_ff.data)
      else $error("word not driven during pulse");
   a_no_contend: assert property ( // see R02
      !GATE_N_O |-> DQ_OE_N_O)
      else $error("host drives data while memory output gated on");
   a_id_levels: assert property ( // see R16
      ID_HIGH_VOLTAGE_O |-> ADDR_O[15:1] == 15'h0000 && !SEL_N_O &&
      !GATE_N_O && !PROGRAM_STROBE_N_O && !VPP_HIGH_O)
      else $error("id read with other lines not low");
   a_vpp_drop: assert property ( // see R17
      $fell(VPP_HIGH_O) |=> VCC_HIGH_O)
      else $error("main supply dropped with programming supply");
endmodule
`default_nettype wire

/* dv/uepc_mem_model.sv */
// Purpose: Behavioural memory on the controller's far side.
// Assumes: Levels only, no clock; a word needs addr[4:0]+1 pulses.
// Notes:   Floating data pins show the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none
module uepc_mem_model #(
   parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_ID  = 8'h5a  // Arbitrary value
) (
   input  wire logic        sel_n_i,
   input  wire logic        gate_n_i,
   input  wire logic        strobe_n_i,
   input  wire logic        vpp_i,
   input  wire logic        vcc_i,
   input  wire logic        id_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] host_i,
   input  wire logic        host_oe_n_i,
   output logic      [15:0] dq_o,
   output logic             bad_o
);
   logic [15:0] mem [logic [15:0]];
   int          hits [logic [15:0]];
   logic [15:0] word;
   logic [15:0] last = 16'h0000;
   logic        upd = 1'b0;
   logic        drive;
   int          n;
   // Strobe ignored unless supply raised
   assign drive = !sel_n_i && !gate_n_i && (strobe_n_i || !vpp_i);
   assign bad_o = (drive && !host_oe_n_i) || (vpp_i && !vcc_i);
   always @(addr_i or id_i or upd) begin
      if (id_i) word = {8'h00, addr_i[0] ? PART_ID : MAKER_ID};
      else if (mem.exists(addr_i)) word = mem[addr_i];
      else word = 16'hffff;
   end
   always @(negedge drive) last = word;
   // Released pins must not look like the last word
   always @* begin
      if (drive) dq_o = word;
      else if (!host_oe_n_i) dq_o = host_i;
      else dq_o = ~last;
   end
   // Slow cells need repeated pulses; a pulse only clears bits
   always @(posedge strobe_n_i) begin
      if (vpp_i && !sel_n_i && gate_n_i) begin
         n = hits.exists(addr_i) ? hits[addr_i] + 1 : 1;
         hits[addr_i] = n;
         if (n > int'(addr_i[4:0])) mem[addr_i] = word & host_i;
         upd = !upd;
      end
   end
endmodule
`default_nettype wire

/* dv/uepc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the programmer controller.
// Assumes: Short pulse parameter; memory model on the pins.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module uepc_ctrl_tb_top;
   import uepc_pkg::*;
   localparam int PULSE_CYC = 20;
   logic clk = 1'b0, rst = 1'b1, valid = 1'b0;
   logic [1:0] op = 2'h0;
   logic [15:0] caddr = 16'h0000, cdata = 16'h0000;
   logic busy, done, fail, sel_n, gate_n, strb_n, vpp, vcc, idhv, oe_n, bad;
   logic [15:0] rdata, addr, dqo, dqi;
   int compares = 0, miscompares = 0, pulses = 0, cycles = 0, lowc = 0;
   logic bad_seen = 1'b0;
   initial forever #20 clk = ~clk;
   uepc_ctrl #(.PULSE_CYC(PULSE_CYC), .MAX_PULSES(25)) uepc_ctrl_i (
      .CORE_CLK_I(clk), .RST_I(rst), .CMD_VALID_I(valid), .CMD_OP_I(op),
      .CMD_ADDR_I(caddr), .CMD_DATA_I(cdata), .BUSY_O(busy), .DONE_O(done),
      .FAIL_O(fail), .RDATA_O(rdata), .SEL_N_O(sel_n), .GATE_N_O(gate_n),
      .PROGRAM_STROBE_N_O(strb_n), .VPP_HIGH_O(vpp), .VCC_HIGH_O(vcc),
      .ID_HIGH_VOLTAGE_O(idhv), .ADDR_O(addr), .DQ_O(dqo),
      .DQ_OE_N_O(oe_n), .DQ_I(dqi));
   uepc_mem_model uepc_mem_model_i (
      .sel_n_i(sel_n), .gate_n_i(gate_n), .strobe_n_i(strb_n),
      .vpp_i(vpp), .vcc_i(vcc), .id_i(idhv), .addr_i(addr),
      .host_i(dqo), .host_oe_n_i(oe_n), .dq_o(dqi), .bad_o(bad));
   always @(negedge strb_n) if (vpp === 1'b1) pulses++;
   // Pulse length and supply order watched all run long
   always @(negedge clk) begin
      if (bad === 1'b1) bad_seen = 1'b1;
      if (strb_n === 1'b0 && vpp === 1'b1) lowc++;
      else lowc = 0;
      if (lowc > PULSE_CYC + 2) bad_seen = 1'b1;
   end
   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         miscompares++;
         results();
      end
   end
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   task automatic run(input logic [1:0] o, input logic [15:0] a,
                      input logic [15:0] d);
      int n;
      pulses = 0;
      op = o;
      caddr = a;
      cdata = d;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      chk("busy", 16'h0001, {15'h0, busy});
      n = 0;
      while (done !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      chk("done", 16'h0001, {15'h0, done});
      chk("idle pins", 16'h0004, {13'h0, strb_n, vpp, vcc});
   endtask
   task automatic t_reset();
      chk("reset pins", 16'h0388,
          {6'h0, sel_n, gate_n, strb_n, vpp, vcc, idhv, oe_n,
           busy, done, fail});
   endtask
   task automatic t_read_erased();
      run(2'h0, 16'h0005, 16'h0000);
      chk("erased word", 16'hffff, rdata);
   endtask
   task automatic t_prog_ok();
      run(2'h1, 16'h0003, 16'h1234);
      chk("pulses", 16'h0004, pulses[15:0]);
      chk("fail", 16'h0000, {15'h0, fail});
      chk("verify word", 16'h1234, rdata);
      run(2'h0, 16'h0003, 16'h0000);
      chk("read back", 16'h1234, rdata);
   endtask
   task automatic t_prog_limit();
      run(2'h1, 16'h001f, 16'h0f0f);
      chk("pulses", 16'h0019, pulses[15:0]);
      chk("fail", 16'h0001, {15'h0, fail});
      chk("verify word", 16'hffff, rdata);
   endtask
   task automatic t_no_undo();
      run(2'h1, 16'h0003, 16'hffff);
      chk("fail", 16'h0001, {15'h0, fail});
      chk("kept word", 16'h1234, rdata);
   endtask
   task automatic t_id();
      run(2'h2, 16'h0000, 16'h0000);
      chk("maker byte", 16'h003c, rdata);
      run(2'h2, 16'h0001, 16'h0000);
      chk("part byte", 16'h005a, rdata);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_read_erased();
      t_prog_ok();
      t_prog_limit();
      t_no_undo();
      t_id();
      chk("pin faults", 16'h0000, {15'h0, bad_seen});
      results();
   end
endmodule
`default_nettype wire
